/* File: verilog/zqc_params.svh */
// timing constants and encodings for the impedance calibration sequencing pair
`ifndef ZQC_PARAMS_SVH
`define ZQC_PARAMS_SVH
// calibration windows in link clock cycles (nCK), plain defaults
`define ZQC_T_INIT_NCK      16'd512
`define ZQC_T_OPER_NCK      16'd256
`define ZQC_T_CS_NCK        16'd64
// least impedance correction of one short calibration, tenths of a percent
`define ZQC_CS_STEP         8'd5
// self-refresh exit delay in nCK
`define ZQC_T_XS_NCK        16'd24
// precharge period in nCK
`define ZQC_T_RP_NCK        16'd11
// link clock divider: half period in system clocks (100 MHz / 8 = 12.5 MHz)
`define ZQC_CK_HALF         8'd4
// address bit that tells long from short calibration
`define ZQC_LONG_BIT        10
// impedance code reset value
`define ZQC_CODE_RESET      8'h80
`endif

/* File: verilog/zqc_pkg.sv */
// types for the impedance calibration sequencing pair
package zqc_pkg;
    // command bus encodings {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        ZQC_CMD_NOP  = 4'h7,
        ZQC_CMD_PREA = 4'h2,
        ZQC_CMD_ZQ   = 4'h6,
        ZQC_CMD_DES  = 4'h8
    } zqc_cmd_t;
    // device calibration engine states
    typedef enum logic [1:0] {
        ZQC_DS_IDLE = 2'b00,
        ZQC_DS_CAL  = 2'b01,
        ZQC_DS_LOAD = 2'b10
    } zqc_dev_state_t;
    // controller sequencer states
    typedef enum logic [2:0] {
        ZQC_HS_IDLE  = 3'b000,
        ZQC_HS_PREA  = 3'b001,
        ZQC_HS_TRP   = 3'b010,
        ZQC_HS_ISSUE = 3'b011,
        ZQC_HS_QUIET = 3'b100,
        ZQC_HS_SRX   = 3'b101
    } zqc_host_state_t;
endpackage : zqc_pkg

/* File: verilog/zqc_link_if.sv */
// command link between controller and device
interface zqc_link_if;
    logic       ck;
    logic       cke;
    logic [3:0] cmd;
    logic       a10;
    logic       odt;
    logic       dq_out;
    logic       dq_oe;
    logic       dq_in;
    modport host (output ck, output cke, output cmd, output a10, output odt, input dq_in);
    modport dev  (input ck, input cke, input cmd, input a10, input odt, output dq_out, output dq_oe);
    // wired data bit: only the device ever drives it here
    assign dq_in = dq_oe ? dq_out : 1'b0;
endinterface : zqc_link_if

/* File: verilog/zqc_host.sv */
// controller end: issues long and short calibrations and keeps the channel quiet
`include "zqc_params.svh"
module zqc_host (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RESET,
    // user requests
    input  wire logic CAL_LONG_REQ,
    input  wire logic CAL_SHORT_REQ,
    input  wire logic SR_EXIT_REQ,
    // user status
    output logic      BUSY,
    output logic      INIT_DONE,
    // link
    zqc_link_if.host  LINK
);
    import zqc_pkg::*;

    zqc_host_state_t state_ff;
    logic [7:0]      div_ff;
    logic            ck_ff;
    logic            long_ff;
    logic            long_seen_ff;
    logic            pend_long_ff;
    logic            pend_short_ff;
    logic [15:0]     cnt_ff;
    logic            zq_issue_ff;
    zqc_cmd_t        cmd_ff;

    wire fall = (div_ff == `ZQC_CK_HALF - 8'd1) && ck_ff; // next edge is a falling one
    wire rise = (div_ff == `ZQC_CK_HALF - 8'd1) && !ck_ff;

    // link clock divider; commands change on falling edges
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            div_ff <= 8'h00;
            ck_ff  <= 1'b0;
        end else if (div_ff == `ZQC_CK_HALF - 8'd1) begin
            div_ff <= 8'h00;
            ck_ff  <= ~ck_ff;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // request latches, cleared at the idle falling edge that takes them or that takes a self-refresh exit instead
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pend_long_ff  <= 1'b0;
            pend_short_ff <= 1'b0;
        end else begin
            if (CAL_LONG_REQ)
                pend_long_ff <= 1'b1;
            else if (state_ff == ZQC_HS_IDLE && fall && pend_long_ff)
                pend_long_ff <= 1'b0;
            if (CAL_SHORT_REQ)
                pend_short_ff <= 1'b1;
            else if (state_ff == ZQC_HS_IDLE && fall && !pend_long_ff && pend_short_ff)
                pend_short_ff <= 1'b0;
        end
    end

    // sequencer: all banks precharged, tRP, calibration, quiet window
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_ff     <= ZQC_HS_IDLE;
            cnt_ff       <= 16'h0000;
            long_ff      <= 1'b0;
            long_seen_ff <= 1'b0;
            cmd_ff       <= ZQC_CMD_NOP;
            zq_issue_ff  <= 1'b0;
        end else if (fall) begin
            cmd_ff <= ZQC_CMD_NOP;
            case (state_ff)
                ZQC_HS_IDLE: begin
                    if (SR_EXIT_REQ) begin
                        cnt_ff   <= `ZQC_T_XS_NCK;
                        state_ff <= ZQC_HS_SRX;
                    end else if (pend_long_ff || pend_short_ff) begin
                        long_ff  <= pend_long_ff;
                        cmd_ff   <= ZQC_CMD_PREA;
                        state_ff <= ZQC_HS_PREA;
                    end
                end
                ZQC_HS_SRX: begin
                    // only no-operations until the exit delay is spent
                    if (cnt_ff <= 16'h0001)
                        state_ff <= ZQC_HS_IDLE;
                    else
                        cnt_ff <= cnt_ff - 16'h0001;
                end
                ZQC_HS_PREA: begin
                    cnt_ff   <= `ZQC_T_RP_NCK;
                    state_ff <= ZQC_HS_TRP;
                end
                ZQC_HS_TRP: begin
                    if (cnt_ff <= 16'h0001) begin
                        cmd_ff      <= ZQC_CMD_ZQ;
                        zq_issue_ff <= 1'b1;
                        state_ff    <= ZQC_HS_ISSUE;
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                ZQC_HS_ISSUE: begin
                    zq_issue_ff <= 1'b0;
                    // window choice depends on whether a long one ran since reset
                    if (!long_ff)
                        cnt_ff <= `ZQC_T_CS_NCK;
                    else if (!long_seen_ff)
                        cnt_ff <= `ZQC_T_INIT_NCK;
                    else
                        cnt_ff <= `ZQC_T_OPER_NCK;
                    if (long_ff)
                        long_seen_ff <= 1'b1;
                    state_ff <= ZQC_HS_QUIET;
                end
                ZQC_HS_QUIET: begin
                    // channel stays idle; a single device on this resistor keeps windows apart
                    if (cnt_ff <= 16'h0001)
                        state_ff <= ZQC_HS_IDLE;
                    else
                        cnt_ff <= cnt_ff - 16'h0001;
                end
                default: state_ff <= ZQC_HS_IDLE;
            endcase
        end
    end

    // link outputs: clock enable high, termination off, long/short address bit
    assign LINK.ck  = ck_ff;
    assign LINK.cke = 1'b1;
    assign LINK.odt = 1'b0;
    assign LINK.cmd = cmd_ff;
    assign LINK.a10 = zq_issue_ff & long_ff;

    // user status
    assign BUSY      = (state_ff != ZQC_HS_IDLE);
    assign INIT_DONE = long_seen_ff && (state_ff == ZQC_HS_IDLE);

    wire unused_ok = rise | LINK.dq_in;
endmodule : zqc_host

/* File: verilog/zqc_dev.sv */
// device end: decodes calibration commands, runs the engine, loads IO impedance codes
`include "zqc_params.svh"
// Function
// - long calibration used first, then when needed; the controller also sends a short one first when only a short is requested
// - long command runs engine, then loads IO
// - first long gets init window, later oper
// - short command for drift, short window
// - short command corrects at least half percent
// - controller keeps channel quiet during windows
// - calibration current off once calibrated
// - all banks precharged, tRP met before calibrating
// - calibration no earlier than self-refresh exit delay
// - no self calibration on self-refresh exit
// - shared resistor windows never overlap
// - clock enable held high during calibration
// - termination held off during calibration
// - all data drivers high impedance during calibration
// - self-refresh exit is clock enable rise with NOP; here clock enable stays high and the exit sends only NOPs
module zqc_dev (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // analog comparison stand-in: target impedance code
    input  wire logic [7:0]  TARGET_CODE,
    // status
    output logic             CAL_ACTIVE,
    output logic             CAL_CURRENT_EN,
    output logic [7:0]       DRV_CODE,
    output logic [7:0]       ODT_CODE,
    // link
    zqc_link_if.dev          LINK
);
    import zqc_pkg::*;

    zqc_dev_state_t state_ff;
    logic [2:0]     ck_sync_ff;
    logic [1:0]     cke_sync_ff;
    logic [3:0]     cmd_sync0_ff;
    logic [3:0]     cmd_sync1_ff;
    logic [1:0]     a10_sync_ff;
    logic           long_seen_ff;
    logic [15:0]    cnt_ff;
    logic [7:0]     eng_code_ff;
    logic [7:0]     drv_code_ff;
    logic [7:0]     odt_code_ff;

    // step toward target by a bounded amount per clock
    function automatic logic [7:0] zqc_step(input logic [7:0] cur, input logic [7:0] tgt, input logic [7:0] s);
        logic [8:0] t;
        t = 9'h000;
        if (cur < tgt) begin
            t = {1'b0, cur} + {1'b0, s};
            zqc_step = (t[7:0] > tgt || t[8]) ? tgt : t[7:0];
        end else begin
            zqc_step = (cur - tgt < s) ? tgt : cur - s;
        end
    endfunction : zqc_step

    // two-stage synchronisers for the link pins
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ck_sync_ff   <= 3'h0;
            cke_sync_ff  <= 2'h0;
            cmd_sync0_ff <= 4'h7;
            cmd_sync1_ff <= 4'h7;
            a10_sync_ff  <= 2'h0;
        end else begin
            ck_sync_ff   <= {ck_sync_ff[1:0], LINK.ck};
            cke_sync_ff  <= {cke_sync_ff[0], LINK.cke};
            cmd_sync0_ff <= LINK.cmd;
            cmd_sync1_ff <= cmd_sync0_ff;
            a10_sync_ff  <= {a10_sync_ff[0], LINK.a10};
        end
    end

    wire ck_rise = ck_sync_ff[1] && !ck_sync_ff[2];
    wire zq_cmd  = ck_rise && cke_sync_ff[1] && (cmd_sync1_ff == ZQC_CMD_ZQ);
    wire is_long = a10_sync_ff[1];

    // calibration engine: only an explicit command starts it, never self-refresh exit
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_ff     <= ZQC_DS_IDLE;
            cnt_ff       <= 16'h0000;
            long_seen_ff <= 1'b0;
            eng_code_ff  <= `ZQC_CODE_RESET;
        end else begin
            case (state_ff)
                ZQC_DS_IDLE: begin
                    if (zq_cmd) begin
                        eng_code_ff <= drv_code_ff;
                        if (!is_long)
                            cnt_ff <= `ZQC_T_CS_NCK;
                        else if (!long_seen_ff)
                            cnt_ff <= `ZQC_T_INIT_NCK;
                        else
                            cnt_ff <= `ZQC_T_OPER_NCK;
                        if (is_long)
                            long_seen_ff <= 1'b1;
                        state_ff <= ZQC_DS_CAL;
                    end
                end
                ZQC_DS_CAL: begin
                    if (ck_rise) begin
                        // short calibration: bounded step per nCK, full range over the window
                        eng_code_ff <= zqc_step(eng_code_ff, TARGET_CODE, `ZQC_CS_STEP);
                        if (cnt_ff <= 16'h0002)
                            state_ff <= ZQC_DS_LOAD;
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                ZQC_DS_LOAD: begin
                    if (ck_rise)
                        state_ff <= ZQC_DS_IDLE;
                end
                default: state_ff <= ZQC_DS_IDLE;
            endcase
        end
    end

    // transfer engine result to IO impedance codes
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            drv_code_ff <= `ZQC_CODE_RESET;
            odt_code_ff <= `ZQC_CODE_RESET;
        end else if (state_ff == ZQC_DS_LOAD && ck_rise) begin
            drv_code_ff <= eng_code_ff;
            odt_code_ff <= eng_code_ff;
        end
    end

    assign CAL_ACTIVE     = (state_ff != ZQC_DS_IDLE);
    assign CAL_CURRENT_EN = (state_ff == ZQC_DS_CAL);
    assign DRV_CODE       = drv_code_ff;
    assign ODT_CODE       = odt_code_ff;
    // data driver stays off; never driven while calibrating
    assign LINK.dq_out    = 1'b0;
    assign LINK.dq_oe     = 1'b0;

    wire unused_ok = LINK.odt;
endmodule : zqc_dev

/* File: verification/zqc_link_checker.sv */
// link protocol checker for the calibration sequencing pair
module zqc_link_checker
    import zqc_pkg::*;
(
    // clock and reset
    input wire logic       CLOCK,
    input wire logic       RESET,
    // link signals
    input wire logic       ck,
    input wire logic       cke,
    input wire logic [3:0] cmd,
    input wire logic       a10,
    input wire logic       odt,
    input wire logic       dq_out,
    input wire logic       dq_oe,
    input wire logic       dq_in
);
    logic [3:0]  prev_cmd_ff;
    logic [12:0] since_zq_ff;
    logic [12:0] quiet_ff;
    logic        long_seen_ff;
    logic        prea_seen_ff;
    logic        zq_start;
    logic        prea_start;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // first system cycle of a new command
    assign zq_start   = (cmd == ZQC_CMD_ZQ) && (prev_cmd_ff != ZQC_CMD_ZQ);
    assign prea_start = (cmd == ZQC_CMD_PREA) && (prev_cmd_ff != ZQC_CMD_PREA);
    // command history
    always_ff @(posedge CLOCK) begin
        prev_cmd_ff <= RESET ? ZQC_CMD_NOP : cmd;
    end
    // cycles since the last calibration command, saturating
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            since_zq_ff <= '1;
        end else if (zq_start) begin
            since_zq_ff <= 13'h1;
        end else if (since_zq_ff != '1) begin
            since_zq_ff <= since_zq_ff + 13'h1;
        end
    end
    // quiet span owed to the last calibration, first long one is longest
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            quiet_ff     <= 13'h0;
            long_seen_ff <= 1'b0;
        end else if (zq_start) begin
            quiet_ff     <= a10 ? (long_seen_ff ? 13'h800 : 13'h1000) : 13'h200;
            long_seen_ff <= long_seen_ff | a10;
        end
    end
    // a precharge-all must precede every calibration
    always_ff @(posedge CLOCK) begin
        prea_seen_ff <= RESET ? 1'b0 : (prea_start | (prea_seen_ff & ~zq_start));
    end
    a_cke_held: assert property (cke == 1'b1) else $error("clock enable low");
    a_odt_off: assert property (odt == 1'b0) else $error("termination enabled");
    a_dq_released: assert property (!dq_oe && dq_in == 1'b0) else $error("data bit driven");
    a_long_qual: assert property (a10 |-> cmd == ZQC_CMD_ZQ) else $error("long bit outside calibration");
    a_zq_needs_prea: assert property (zq_start |-> prea_seen_ff) else $error("calibration without precharge");
    a_prea_to_zq: assert property (prea_start |-> ##[90:100] zq_start) else $error("precharge period wrong");
    a_quiet_window: assert property ((zq_start || (cmd != ZQC_CMD_NOP && cmd != ZQC_CMD_ZQ))
        |-> since_zq_ff >= quiet_ff) else $error("command inside calibration window");
    a_cmd_stands: assert property ($changed(cmd) |=> $stable(cmd) [*7]) else $error("command shorter than one link cycle");
    a_ck_period: assert property ($changed(ck) |=> $stable(ck) [*3] ##1 $changed(ck)) else $error("link clock period wrong");
    c_first_long: cover property (zq_start && a10 && !long_seen_ff);
    c_later_long: cover property (zq_start && a10 && long_seen_ff);
    c_short: cover property (zq_start && !a10);
endmodule : zqc_link_checker

/* File: verification/testbench.sv */
// self-checking bench for the calibration sequencing pair
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        long_req = 1'b0;
    logic        short_req = 1'b0;
    logic        srx_req = 1'b0;
    logic [7:0]  target = 8'h80;
    logic        busy, init_done, cal_active, cur_en;
    logic [7:0]  drv_code, odt_code;
    logic [31:0] nck;
    logic        act_seen = 1'b0;
    int          mismatches = 0;
    int          samples_checked = 0;
    zqc_link_if link();
    zqc_host i_zqc_host (.CLOCK(clock), .RESET(reset), .CAL_LONG_REQ(long_req), .CAL_SHORT_REQ(short_req),
        .SR_EXIT_REQ(srx_req), .BUSY(busy), .INIT_DONE(init_done), .LINK(link.host));
    zqc_dev i_zqc_dev (.CLOCK(clock), .RESET(reset), .TARGET_CODE(target), .CAL_ACTIVE(cal_active),
        .CAL_CURRENT_EN(cur_en), .DRV_CODE(drv_code), .ODT_CODE(odt_code), .LINK(link.dev));
    zqc_link_checker i_zqc_link_checker (.CLOCK(clock), .RESET(reset), .ck(link.ck), .cke(link.cke),
        .cmd(link.cmd), .a10(link.a10), .odt(link.odt), .dq_out(link.dq_out), .dq_oe(link.dq_oe),
        .dq_in(link.dq_in));
    // system clock, 10 ns period
    always #5 clock = ~clock;
    // remember any engine activity
    always @(posedge clock) begin
        if (cal_active === 1'b1) act_seen = 1'b1;
    end
    // value comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // synchronous reset held for 10 cycles
    task automatic do_reset();
        @(negedge clock);
        reset = 1'b1;
        repeat (10) @(negedge clock);
        reset = 1'b0;
    endtask : do_reset
    // pulse calibration requests for one clock (a held level would latch again and rerun),
    // hold the self-refresh exit level until busy, then measure busy length in link cycles
    task automatic run_cal(input logic lng, input logic sht, input logic srx, output logic [31:0] len);
        int n;
        n = 0;
        @(negedge clock);
        long_req = lng;
        short_req = sht;
        srx_req = srx;
        @(negedge clock);
        long_req = 1'b0;
        short_req = 1'b0;
        while (busy !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        srx_req = 1'b0;
        n = 0;
        while (busy === 1'b1 && n < 9000) begin
            @(negedge clock);
            n++;
        end
        len = (n + 4) / 8;
    endtask : run_cal
    // state straight after reset
    task automatic t_reset();
        check(busy, 0);
        check(init_done, 0);
        check(drv_code, 8'h80);
        check(odt_code, 8'h80);
        check(cur_en, 0);
    endtask : t_reset
    // long calibration, first one after reset
    task automatic t_first_long();
        target = 8'h40;
        act_seen = 1'b0;
        run_cal(1'b1, 1'b0, 1'b0, nck);
        check(nck, 13 + 512);
        check(act_seen, 1);
        check(drv_code, 8'h40);
        check(odt_code, 8'h40);
        check(init_done, 1);
        check(cur_en, 0);
    endtask : t_first_long
    // later long calibration uses the operational window
    task automatic t_later_long();
        target = 8'h30;
        run_cal(1'b1, 1'b0, 1'b0, nck);
        check(nck, 13 + 256);
        check(drv_code, 8'h30);
    endtask : t_later_long
    // short calibration corrects a drift of 20 code steps
    task automatic t_short();
        target = 8'h44;
        run_cal(1'b0, 1'b1, 1'b0, nck);
        check(nck, 13 + 64);
        check(drv_code, 8'h44);
        check(odt_code, 8'h44);
    endtask : t_short
    // self-refresh exit waits but never calibrates by itself
    task automatic t_sr_exit();
        target = 8'h10;
        act_seen = 1'b0;
        run_cal(1'b0, 1'b0, 1'b1, nck);
        check(nck, 24);
        check(act_seen, 0);
        check(drv_code, 8'h44);
    endtask : t_sr_exit
    // long and short together: long first, short held until after
    task automatic t_back_to_back();
        run_cal(1'b1, 1'b1, 1'b0, nck);
        check(nck, 13 + 256);
        run_cal(1'b0, 1'b0, 1'b0, nck);
        check(nck, 13 + 64);
        check(drv_code, 8'h10);
    endtask : t_back_to_back
    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // watchdog
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        conclude();
    end
    // main sequence, with a second reset to restore the initial window
    initial begin
        do_reset();
        t_reset();
        t_first_long();
        t_later_long();
        t_short();
        t_sr_exit();
        t_back_to_back();
        do_reset();
        t_reset();
        t_first_long();
        conclude();
    end
endmodule : testbench
